/* design/pais_pkg.sv */
package pais_pkg;
    // register offsets, as printed
    localparam logic [7:0] REG_CH1_SEL    = 8'h07;
    localparam logic [7:0] REG_CH2_SEL    = 8'h08;
    localparam logic [7:0] REG_CH3_SEL    = 8'h09;
    localparam logic [7:0] REG_RECOVERY   = 8'h0a;
    localparam logic [7:0] REG_GAIN       = 8'h0b;
    localparam logic [7:0] REG_MISC       = 8'h0c;
    localparam logic [7:0] REG_CTRL       = 8'h20;
    localparam logic [7:0] REG_STATUS     = 8'h21;
    // reset values
    localparam logic [7:0] RST_SEL        = 8'h03;
    localparam logic [7:0] RST_RECOVERY   = 8'h70;
    localparam logic [7:0] RST_GAIN       = 8'h00;
    localparam logic [7:0] RST_MISC       = 8'h04;
    // field positions and masks
    localparam int         REC_LSB        = 4;
    localparam logic [7:0] REC_MASK       = 8'h70;
    localparam logic [7:0] GAIN_MASK      = 8'h07;
    localparam logic [7:0] MISC_MASK      = 8'h24;
    localparam int         MODE_BIT       = 2;
    // input select codes
    localparam logic [7:0] SEL_SMALL_IR   = 8'h00;
    localparam logic [7:0] SEL_VISIBLE    = 8'h02;
    localparam logic [7:0] SEL_LARGE_IR   = 8'h03;
    localparam logic [7:0] SEL_NO_DIODE   = 8'h06;
    localparam logic [7:0] SEL_GND        = 8'h25;
    localparam logic [7:0] SEL_TEMP       = 8'h65;
    localparam logic [7:0] SEL_VDD        = 8'h75;
    // timing: one converter clock of recovery
    localparam int         CLK_PERIOD_PS  = 25000;
    localparam int         ADC_CLK_PS     = 50000;
    localparam int         ADC_CLK_CYC    = (ADC_CLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         CNT_W          = 20;

    typedef enum logic [2:0] {
        PAIS_IN_SMALL_IR,
        PAIS_IN_LARGE_IR,
        PAIS_IN_VISIBLE,
        PAIS_IN_NONE,
        PAIS_IN_GND,
        PAIS_IN_TEMP,
        PAIS_IN_VDD,
        PAIS_IN_UNDEF
    } pais_input_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pais_bus_s;

    typedef struct packed {
        logic [1:0]  channel;
        pais_input_e route;
        logic        led_enable;
        logic        raw_mode;
        logic [2:0]  gain;
    } pais_conv_s;
endpackage : pais_pkg

/* design/pais_recovery_timer.sv */
`timescale 1ns/1ps
// counts converter clocks of recovery, stretched by the gain exponent
module pais_recovery_timer (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      start_i,
    input  wire logic [2:0]                code_i,
    input  wire logic [2:0]                gain_i,
    output logic                           done_o
);
    logic [pais_pkg::CNT_W-1:0] count;
    logic                       busy;
    logic [pais_pkg::CNT_W-1:0] adc_clocks;
    logic [pais_pkg::CNT_W-1:0] load_value;

    // code n gives 2^(n+2)-1 clocks, except code 0 gives 1
    assign adc_clocks = (code_i == 3'h0) ? pais_pkg::CNT_W'(1)
                      : pais_pkg::CNT_W'((32'h1 << (32'(code_i) + 32'h2)) - 32'h1);
    // each clock is 50 ns = ADC_CLK_CYC system cycles, times 2^gain
    assign load_value = pais_pkg::CNT_W'((32'(adc_clocks) * 32'(pais_pkg::ADC_CLK_CYC)) << gain_i);

    // down counter; done pulses one cycle after the last count
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count  <= '0;
            busy   <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= busy && (count == pais_pkg::CNT_W'(1));
            if (start_i)
            begin
                count <= load_value;
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                count <= count - pais_pkg::CNT_W'(1);
                busy  <= (count != pais_pkg::CNT_W'(1));
            end
        end
    end
endmodule : pais_recovery_timer

/* design/pais_input_select.sv */
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module pais_input_select (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [2:0] conv_req_i,
    input  wire logic       conv_done_i,
    output logic [7:0]      rdata_o,
    output logic            conv_start_o,
    output logic [1:0]      conv_channel_o,
    output logic [2:0]      conv_route_o,
    output logic            led_enable_o,
    output logic            raw_mode_o,
    output logic [2:0]      gain_exponent_o,
    output logic [19:0]     integration_cycles_o,
    output logic            recovering_o,
    output logic            busy_o
);
    typedef enum logic [1:0] {
        PAIS_IDLE,
        PAIS_RECOVER,
        PAIS_CONVERT
    } pais_state_e;

    pais_pkg::pais_bus_s  bus;
    pais_pkg::pais_conv_s next_conv;
    pais_state_e          state;
    logic [7:0]           ch_sel [3];
    logic [7:0]           recovery;
    logic [7:0]           gain_reg;
    logic [7:0]           misc;
    logic [7:0]           ctrl;
    logic [1:0]           active_ch;
    logic [7:0]           next_rdata;
    logic                 normal_mode;
    logic                 rec_done;
    logic                 pick_valid;
    logic [1:0]           pick_ch;
    logic                 start_pulse;
    logic                 in_idle;
    logic                 in_recover;
    logic                 in_convert;
    logic [19:0]          next_integration;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // maps a stored select code to a converter input
    function automatic pais_pkg::pais_input_e decode_sel(input logic [7:0] code, input logic normal);
        pais_pkg::pais_input_e r;
        r = pais_pkg::PAIS_IN_UNDEF;
        if (code == pais_pkg::SEL_LARGE_IR)
            r = pais_pkg::PAIS_IN_LARGE_IR;
        else if (code == pais_pkg::SEL_SMALL_IR)
            r = pais_pkg::PAIS_IN_SMALL_IR;
        else if (!normal && code == pais_pkg::SEL_VISIBLE)
            r = pais_pkg::PAIS_IN_VISIBLE;
        else if (!normal && code == pais_pkg::SEL_NO_DIODE)
            r = pais_pkg::PAIS_IN_NONE;
        else if (!normal && code == pais_pkg::SEL_GND)
            r = pais_pkg::PAIS_IN_GND;
        else if (!normal && code == pais_pkg::SEL_TEMP)
            r = pais_pkg::PAIS_IN_TEMP;
        else if (!normal && code == pais_pkg::SEL_VDD)
            r = pais_pkg::PAIS_IN_VDD;
        return r;
    endfunction : decode_sel

    assign normal_mode = misc[pais_pkg::MODE_BIT];

    // sequencer phase decodes, shared by the start logic and the output flops
    assign in_idle    = (state == PAIS_IDLE);
    assign in_recover = (state == PAIS_RECOVER);
    assign in_convert = (state == PAIS_CONVERT);

    // lowest requested channel wins when several ask at once
    assign pick_valid = |conv_req_i;
    assign pick_ch    = conv_req_i[0] ? 2'd0 : (conv_req_i[1] ? 2'd1 : 2'd2);
    assign start_pulse = in_idle && pick_valid;

    // all three channels decode through the same code set
    assign next_conv.channel    = active_ch;
    assign next_conv.route      = decode_sel(ch_sel[active_ch], normal_mode);
    assign next_conv.led_enable = normal_mode;
    assign next_conv.raw_mode   = !normal_mode;
    assign next_conv.gain       = gain_reg[2:0];

    // one converter clock stretched by 2^gain; fits 20 bits even at gain 7
    assign next_integration = 20'(32'(pais_pkg::ADC_CLK_CYC) << next_conv.gain);

    // read mux; unmapped offsets read zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (bus.addr)
            pais_pkg::REG_CH1_SEL:  next_rdata = ch_sel[0];
            pais_pkg::REG_CH2_SEL:  next_rdata = ch_sel[1];
            pais_pkg::REG_CH3_SEL:  next_rdata = ch_sel[2];
            pais_pkg::REG_RECOVERY: next_rdata = recovery;
            pais_pkg::REG_GAIN:     next_rdata = gain_reg;
            pais_pkg::REG_MISC:     next_rdata = misc;
            pais_pkg::REG_CTRL:     next_rdata = ctrl;
            pais_pkg::REG_STATUS:   next_rdata = {4'h0, 2'(state), active_ch};
            default:                next_rdata = 8'h00;
        endcase
    end

    // register writes; undocumented codes stored as written
    // reserved bits of recovery, gain and misc are masked on write so they read back as zero; ctrl keeps all written bits
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ch_sel[0] <= pais_pkg::RST_SEL;
            ch_sel[1] <= pais_pkg::RST_SEL;
            ch_sel[2] <= pais_pkg::RST_SEL;
            recovery  <= pais_pkg::RST_RECOVERY;
            gain_reg  <= pais_pkg::RST_GAIN;
            misc      <= pais_pkg::RST_MISC;
            ctrl      <= 8'h00;
            rdata_o   <= 8'h00;
        end
        else
        begin
            rdata_o <= bus.rd ? next_rdata : 8'h00;
            if (bus.wr)
            begin
                unique case (bus.addr)
                    pais_pkg::REG_CH1_SEL:  ch_sel[0] <= bus.wdata;
                    pais_pkg::REG_CH2_SEL:  ch_sel[1] <= bus.wdata;
                    pais_pkg::REG_CH3_SEL:  ch_sel[2] <= bus.wdata;
                    pais_pkg::REG_RECOVERY: recovery  <= bus.wdata & pais_pkg::REC_MASK;
                    pais_pkg::REG_GAIN:     gain_reg  <= bus.wdata & pais_pkg::GAIN_MASK;
                    pais_pkg::REG_MISC:     misc      <= bus.wdata & pais_pkg::MISC_MASK;
                    pais_pkg::REG_CTRL:     ctrl      <= bus.wdata;
                    default:                ;
                endcase
            end
        end
    end

    // recovery delay before every conversion
    pais_recovery_timer u_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .start_i (start_pulse),
        .code_i  (recovery[pais_pkg::REC_LSB +: 3]),
        .gain_i  (gain_reg[2:0]),
        .done_o  (rec_done)
    );

    // sequencer: idle -> recover -> convert -> idle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state     <= PAIS_IDLE;
            active_ch <= 2'd0;
        end
        else
        begin
            unique case (state)
                PAIS_IDLE:
                    if (pick_valid)
                    begin
                        state     <= PAIS_RECOVER;
                        active_ch <= pick_ch;
                    end
                PAIS_RECOVER:
                    if (rec_done)
                        state <= PAIS_CONVERT;
                PAIS_CONVERT:
                    if (conv_done_i)
                        state <= PAIS_IDLE;
            endcase
        end
    end

    // conversion outputs registered; LED only during normal-mode conversion
    // integration resets to its gain-zero length so it agrees with the gain register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            conv_start_o         <= 1'b0;
            conv_channel_o       <= 2'd0;
            conv_route_o         <= 3'(pais_pkg::PAIS_IN_LARGE_IR);
            led_enable_o         <= 1'b0;
            raw_mode_o           <= 1'b0;
            gain_exponent_o      <= 3'h0;
            integration_cycles_o <= 20'(pais_pkg::ADC_CLK_CYC);
            recovering_o         <= 1'b0;
            busy_o               <= 1'b0;
        end
        else
        begin
            conv_start_o         <= in_recover && rec_done;
            conv_channel_o       <= next_conv.channel;
            conv_route_o         <= 3'(next_conv.route);
            led_enable_o         <= next_conv.led_enable && in_convert;
            raw_mode_o           <= next_conv.raw_mode;
            gain_exponent_o      <= next_conv.gain;
            integration_cycles_o <= next_integration;
            recovering_o         <= in_recover;
            busy_o               <= !in_idle;
        end
    end
endmodule : pais_input_select

/* verif/pais_input_select_checker.sv */
`timescale 1ns/1ps
// port-level watch on read timing and the conversion sequence
module pais_checker (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        rd_i,
    input  wire logic [2:0]  conv_req_i,
    input  wire logic [7:0]  rdata_o,
    input  wire logic        conv_start_o,
    input  wire logic [1:0]  conv_channel_o,
    input  wire logic        led_enable_o,
    input  wire logic        raw_mode_o,
    input  wire logic [2:0]  gain_exponent_o,
    input  wire logic [19:0] integration_cycles_o,
    input  wire logic        recovering_o,
    input  wire logic        busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // read data only in the cycle after a read strobe
    property p_rd_quiet; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its cycle");
    property p_raw_no_led; raw_mode_o |-> !led_enable_o; endproperty
    a_raw_no_led: assert property (p_raw_no_led) else $error("led on in raw mode");
    property p_led_start; conv_start_o && !raw_mode_o |=> led_enable_o; endproperty
    a_led_start: assert property (p_led_start) else $error("no led after start");
    property p_led_phase; led_enable_o |-> busy_o && !recovering_o; endproperty
    a_led_phase: assert property (p_led_phase) else $error("led outside convert");
    property p_start_pulse; conv_start_o |=> !conv_start_o; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
    // status flags are registered, so they show the take one cycle late
    property p_take; !busy_o && conv_req_i != 3'h0 |-> ##2 busy_o && recovering_o; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    // shortest recovery is one converter clock of two cycles, so no early start
    property p_min_rec; $rose(recovering_o) |-> !conv_start_o [*2]; endproperty
    a_min_rec: assert property (p_min_rec) else $error("recovery too short");
    property p_lowest; !busy_o && conv_req_i[0] |-> ##2 conv_channel_o == 2'h0; endproperty
    a_lowest: assert property (p_lowest) else $error("wrong channel taken");
    property p_gain;
        $stable(gain_exponent_o) |-> integration_cycles_o == (20'(pais_pkg::ADC_CLK_CYC) << gain_exponent_o);
    endproperty
    a_gain: assert property (p_gain) else $error("integration not scaled by gain");
endmodule : pais_checker

bind pais_input_select pais_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_i(rd_i),
    .conv_req_i(conv_req_i), .rdata_o(rdata_o), .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
    .led_enable_o(led_enable_o), .raw_mode_o(raw_mode_o), .gain_exponent_o(gain_exponent_o),
    .integration_cycles_o(integration_cycles_o), .recovering_o(recovering_o), .busy_o(busy_o));

/* verif/testbench.sv */
`timescale 1ns/1ps
// register access and conversions checked against select codes and recovery times
module testbench;
    logic        clk_i;
    logic        rst_n_i;
    logic [7:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [2:0]  conv_req_i;
    logic        conv_done_i;
    logic [7:0]  rdata_o;
    logic        conv_start_o;
    logic [1:0]  conv_channel_o;
    logic [2:0]  conv_route_o;
    logic        led_enable_o;
    logic        raw_mode_o;
    logic [2:0]  gain_exponent_o;
    logic [19:0] integration_cycles_o;
    logic        recovering_o;
    logic        busy_o;
    int          errors;
    int          comparisons;
    int          cycles;
    // raw-mode codes and routes; visible comes before the dark reference it is subtracted
    localparam logic [7:0] RAW_SEL [7] = '{8'h02, 8'h06, 8'h25, 8'h65, 8'h75, 8'h00, 8'h03};
    localparam logic [2:0] RAW_RT  [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h1};
    // recovery code and gain pairs; the last is the complement pairing
    localparam logic [2:0] REC_C   [4] = '{3'h1, 3'h0, 3'h2, 3'h6};
    localparam logic [2:0] REC_G   [4] = '{3'h0, 3'h2, 3'h1, 3'h1};

    pais_input_select dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .conv_req_i(conv_req_i), .conv_done_i(conv_done_i), .rdata_o(rdata_o),
        .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .conv_route_o(conv_route_o),
        .led_enable_o(led_enable_o), .raw_mode_o(raw_mode_o), .gain_exponent_o(gain_exponent_o),
        .integration_cycles_o(integration_cycles_o), .recovering_o(recovering_o), .busy_o(busy_o));

    task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk("read data", rdata_o, exp);
    endtask : rd

    // converter clocks times cycles per clock times gain scale, plus the done-to-start edge
    function automatic int rec(input int code, input int gain);
        rec = (code == 0 ? 1 : (1 << (code + 2)) - 1) * pais_pkg::ADC_CLK_CYC * (1 << gain) + 1;
    endfunction : rec

    // request is dropped after the take edge so it cannot retrigger after done
    task automatic conv(input logic [2:0] req, input int cyc, input logic [1:0] ch, input logic [2:0] rt,
                        input logic led);
        int n;
        n = 0;
        @(posedge clk_i);
        conv_req_i <= req;
        @(posedge clk_i);
        conv_req_i <= 3'h0;
        do
        begin
            @(posedge clk_i);
            #1 n++;
        end
        while (conv_start_o !== 1'b1 && n < 1100);
        chk("recovery cycles", n, cyc);
        chk("recovering", recovering_o, 1'b1);
        @(posedge clk_i);
        #1 chk("channel", conv_channel_o, ch);
        chk("route", conv_route_o, rt);
        chk("led", led_enable_o, led);
        chk("raw mode", raw_mode_o, !led);
        @(posedge clk_i);
        conv_done_i <= 1'b1;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk("busy after done", busy_o, 1'b0);
    endtask : conv

    // clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // hang guard, far above the roughly 1300 cycles the sequence needs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    // main sequence
    initial
    begin
        rst_n_i = 1'b0;
        {addr_i, wdata_i, wr_i, rd_i, conv_req_i, conv_done_i} = '0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 chk("route at reset", conv_route_o, 3'h1);
        rd(8'h07, 8'h03);
        rd(8'h08, 8'h03);
        rd(8'h09, 8'h03);
        rd(8'h0a, 8'h70);
        rd(8'h0c, 8'h04);
        rd(8'h3f, 8'h00);
        wr(8'h0a, 8'ha5);
        rd(8'h0a, 8'h20);
        wr(8'h08, 8'ha5);
        rd(8'h08, 8'ha5);
        wr(8'h0a, 8'h00);
        wr(8'h07, 8'h00);
        conv(3'b001, rec(0, 0), 2'h0, 3'h0, 1'b1);
        wr(8'h07, 8'h03);
        conv(3'b011, rec(0, 0), 2'h0, 3'h1, 1'b1);
        wr(8'h07, 8'h02);
        conv(3'b111, rec(0, 0), 2'h0, 3'h7, 1'b1);
        wr(8'h0c, 8'h00);
        for (int i = 0; i < 7; i++)
        begin
            wr(8'h09, RAW_SEL[i]);
            conv(3'b100, rec(0, 0), 2'h2, RAW_RT[i], 1'b0);
        end
        wr(8'h0c, 8'h04);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h0a, {1'b0, REC_C[i], 4'h0});
            wr(8'h0b, {5'h00, REC_G[i]});
            conv(3'b010, rec(REC_C[i], REC_G[i]), 2'h1, 3'h7, 1'b1);
            chk("gain exponent", gain_exponent_o, REC_G[i]);
            chk("integration", integration_cycles_o, 20'(pais_pkg::ADC_CLK_CYC) << REC_G[i]);
        end
        rd(8'h0b, 8'h01);
        results();
    end
endmodule : testbench
